// *** design/timer_split_mode_control.sv ***
`timescale 1ns/100ps
// Functional notes
// - Mode 3 splits timer A into two bytes
// - Low byte uses timer A controls and flag
// - Low byte counts clock path or pin
// - High byte counts internal clock ticks only
// - High byte runs only while timer_b_run set
// - High byte overflow sets timer B flag
// - Timer B mode 3 holds its count
// - Split: timer B no pin, no flag
// - Timer B overflow still ticks serial, converter
// - Count needs run and gate condition; in split, high byte ignores the gate, timer B its run bit
// - Run does not reload the count
// - Pin counts on falling edges
// - Clock select: system or prescaled clock
module timer_split_mode_control #(
  parameter int ADDR_W = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic [7:0]  sfrWrData,
  input  wire logic        sfrBitWrEn,
  input  wire logic [2:0]  sfrBitIdx,
  input  wire logic        sfrBitVal,
  output logic      [7:0]  sfrRdData,
  input  wire logic [1:0]  timerAModeSel,
  input  wire logic [1:0]  timerBModeSel,
  input  wire logic        timer_a_count_source_sel,
  input  wire logic        timerBCountSourceSel,
  input  wire logic        timer_a_gate_sel,
  input  wire logic        timerBGateSel,
  input  wire logic        timer_a_sysclk_sel,
  input  wire logic        timerBSysclkSel,
  input  wire logic        prescaleTick,
  input  wire logic        timerAPin,
  input  wire logic        timerBPin,
  input  wire logic        timer_a_gate_input,
  input  wire logic        timerBGateInput,
  input  wire logic [1:0]  gate_input_polarity,
  input  wire logic        isrEnterA,
  input  wire logic        isrEnterB,
  output logic             timerAIrq,
  output logic             timerBIrq,
  output logic             timerBOverflowTick
);

  if (ADDR_W != 8)
    $error("timer_split_mode_control: ADDR_W must be 8");

  typedef struct packed {
    logic       flagA;
    logic       flagB;
    logic       runA;
    logic       runB;
    logic [3:0] extBits;
    logic [7:0] lowA;
    logic [7:0] highA;
    logic [7:0] lowB;
    logic [7:0] highB;
    logic       ovfTickB;
    logic [7:0] rdData;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  timer_tick_if tkA ();
  timer_tick_if tkB ();

  logic splitMode;
  logic [7:0] runFlagsVal;

  ////////////////////////////////////////////////////////////////////////////
  // One count step in modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] countStep(input logic [1:0] mode,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [16:0] res;
    logic [13:0] v13;
    logic [16:0] v16;
    res = {1'b0, hi, lo};
    v13 = {1'b0, hi, lo[timer_split_pkg::MODE0_LOW-1:0]} + 14'h0001;
    v16 = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      timer_split_pkg::MODE_13BIT:
        res = {v13[13], v13[12:5], lo[7:timer_split_pkg::MODE0_LOW], v13[4:0]};
      timer_split_pkg::MODE_16BIT:
        res = v16;
      timer_split_pkg::MODE_RELOAD:
        if (lo == timer_split_pkg::BYTE_MAX)
          res = {1'b1, hi, hi};
        else
          res = {1'b0, hi, lo + 8'h01};
      default:
        res = {1'b0, hi, lo};
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick generators for both timers
  assign splitMode = (timerAModeSel == timer_split_pkg::MODE_SPLIT);

  assign tkA.runEn        = st_r.runA;
  assign tkA.gateSel      = timer_a_gate_sel;
  assign tkA.gateIn       = timer_a_gate_input;
  assign tkA.gatePol      = gate_input_polarity[0];
  assign tkA.srcSel       = timer_a_count_source_sel;
  assign tkA.sysclkSel    = timer_a_sysclk_sel;
  assign tkA.prescaleTick = prescaleTick;
  assign tkA.pin          = timerAPin;

  // In split mode timer B runs by its mode field, its run bit is borrowed
  assign tkB.runEn        = splitMode ? (timerBModeSel != timer_split_pkg::MODE_SPLIT)
                                      : st_r.runB;
  assign tkB.gateSel      = timerBGateSel;
  assign tkB.gateIn       = timerBGateInput;
  assign tkB.gatePol      = gate_input_polarity[1];
  assign tkB.srcSel       = splitMode ? 1'b0 : timerBCountSourceSel;
  assign tkB.sysclkSel    = timerBSysclkSel;
  assign tkB.prescaleTick = prescaleTick;
  assign tkB.pin          = timerBPin;

  timer_tick_gen uTickA (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tk      (tkA.gen)
  );

  timer_tick_gen uTickB (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tk      (tkB.gen)
  );

  assign runFlagsVal = {st_r.flagB, st_r.runB, st_r.flagA, st_r.runA, st_r.extBits};

  ////////////////////////////////////////////////////////////////////////////
  // Counting, flags and register access
  always_comb
  begin
    logic [16:0] stepA;
    logic [16:0] stepB;
    logic [8:0]  lowInc;
    logic [8:0]  highInc;
    logic        ovfA;
    logic        ovfB;
    logic        ovfHighA;
    logic [7:0]  rf;
    stepA    = countStep(timerAModeSel, st_r.highA, st_r.lowA);
    stepB    = countStep(timerBModeSel, st_r.highB, st_r.lowB);
    lowInc   = {1'b0, st_r.lowA} + 9'h001;
    highInc  = {1'b0, st_r.highA} + 9'h001;
    ovfA     = 1'b0;
    ovfB     = 1'b0;
    ovfHighA = 1'b0;
    rf       = runFlagsVal;
    st_nxt   = st_r;

    // Timer A: split into two bytes or one counter; count kept as is on run
    if (splitMode)
    begin
      if (tkA.countEn && tkA.tick)
      begin
        st_nxt.lowA = lowInc[7:0];
        ovfA        = lowInc[8];
      end
      if (st_r.runB && tkA.tickInt)
      begin
        st_nxt.highA = highInc[7:0];
        ovfHighA     = highInc[8];
      end
    end
    else if (tkA.countEn && tkA.tick)
    begin
      st_nxt.highA = stepA[15:8];
      st_nxt.lowA  = stepA[7:0];
      ovfA         = stepA[16];
    end

    // Timer B: mode 3 holds the count
    if (tkB.countEn && tkB.tick && timerBModeSel != timer_split_pkg::MODE_SPLIT)
    begin
      st_nxt.highB = stepB[15:8];
      st_nxt.lowB  = stepB[7:0];
      ovfB         = stepB[16];
    end
    st_nxt.ovfTickB = ovfB;

    // Software writes to the control register, byte or single bit
    if (sfrWrEn && sfrAddr == timer_split_pkg::ADDR_RUN_FLAGS)
      rf = sfrWrData;
    else if (sfrBitWrEn && sfrAddr == timer_split_pkg::ADDR_RUN_FLAGS)
      rf[sfrBitIdx] = sfrBitVal;
    st_nxt.runA    = rf[timer_split_pkg::BIT_A_RUN];
    st_nxt.runB    = rf[timer_split_pkg::BIT_B_RUN];
    st_nxt.extBits = rf[3:0];

    // Flags: service entry clears, hardware set wins over any clear
    st_nxt.flagA = rf[timer_split_pkg::BIT_A_FLAG] & ~isrEnterA;
    st_nxt.flagB = rf[timer_split_pkg::BIT_B_FLAG] & ~isrEnterB;
    if (ovfA)
      st_nxt.flagA = 1'b1;
    if (splitMode ? ovfHighA : ovfB)
      st_nxt.flagB = 1'b1;

    // Software writes to count bytes take priority over counting
    if (sfrWrEn)
    begin
      case (sfrAddr)
        timer_split_pkg::ADDR_A_LOW:  st_nxt.lowA  = sfrWrData;
        timer_split_pkg::ADDR_A_HIGH: st_nxt.highA = sfrWrData;
        timer_split_pkg::ADDR_B_LOW:  st_nxt.lowB  = sfrWrData;
        timer_split_pkg::ADDR_B_HIGH: st_nxt.highB = sfrWrData;
        default:                      st_nxt.rdData = st_r.rdData;
      endcase
    end

    // Registered read data, unmapped reads as zero
    case (sfrAddr)
      timer_split_pkg::ADDR_RUN_FLAGS: st_nxt.rdData = runFlagsVal;
      timer_split_pkg::ADDR_A_LOW:     st_nxt.rdData = st_r.lowA;
      timer_split_pkg::ADDR_A_HIGH:    st_nxt.rdData = st_r.highA;
      timer_split_pkg::ADDR_B_LOW:     st_nxt.rdData = st_r.lowB;
      timer_split_pkg::ADDR_B_HIGH:    st_nxt.rdData = st_r.highB;
      default:                         st_nxt.rdData = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r          <= '0;
      st_r.extBits  <= timer_split_pkg::EXT_BITS_RST;
      st_r.lowA     <= timer_split_pkg::COUNT_RST;
      st_r.highA    <= timer_split_pkg::COUNT_RST;
      st_r.lowB     <= timer_split_pkg::COUNT_RST;
      st_r.highB    <= timer_split_pkg::COUNT_RST;
      st_r.rdData   <= timer_split_pkg::RUN_FLAGS_RST;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flip-flops
  assign sfrRdData          = st_r.rdData;
  assign timerAIrq          = st_r.flagA;
  assign timerBIrq          = st_r.flagB;
  assign timerBOverflowTick = st_r.ovfTickB;

endmodule

// *** design/timer_split_pkg.sv ***
package timer_split_pkg;

  // Register bus addresses
  localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_A_LOW     = 8'h8A;
  localparam logic [7:0] ADDR_B_LOW     = 8'h8B;
  localparam logic [7:0] ADDR_A_HIGH    = 8'h8C;
  localparam logic [7:0] ADDR_B_HIGH    = 8'h8D;

  // Field positions in timer_run_and_flags
  localparam int BIT_B_FLAG = 7;
  localparam int BIT_B_RUN  = 6;
  localparam int BIT_A_FLAG = 5;
  localparam int BIT_A_RUN  = 4;

  // Reset values
  localparam logic [7:0] RUN_FLAGS_RST = 8'h00;
  localparam logic [7:0] COUNT_RST     = 8'h00;
  localparam logic [3:0] EXT_BITS_RST  = 4'h0;

  // Counter geometry
  localparam int         COUNT_W    = 8;
  localparam int         MODE0_LOW  = 5;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_t;

endpackage

// *** design/timer_tick_gen.sv ***
`timescale 1ns/100ps
module timer_tick_gen (
  input  wire logic   clk_sys,
  input  wire logic   srst,
  timer_tick_if.gen   tk
);

  typedef struct packed {
    logic pinPrev;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;
  logic        pinFall;

  ////////////////////////////////////////////////////////////////////////////
  // Pin history for falling edge detection
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.pinPrev = tk.pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick source and enable
  assign pinFall    = st_r.pinPrev & ~tk.pin;
  assign tk.tickInt = tk.sysclkSel ? 1'b1 : tk.prescaleTick;
  assign tk.tick    = tk.srcSel ? pinFall : tk.tickInt;
  assign tk.countEn = tk.runEn & (~tk.gateSel | (tk.gateIn == tk.gatePol));

endmodule

// *** design/timer_tick_if.sv ***
`timescale 1ns/100ps
interface timer_tick_if;
  logic runEn;
  logic gateSel;
  logic gateIn;
  logic gatePol;
  logic srcSel;
  logic sysclkSel;
  logic prescaleTick;
  logic pin;
  logic tickInt;
  logic tick;
  logic countEn;

  modport gen (
    input  runEn,
    input  gateSel,
    input  gateIn,
    input  gatePol,
    input  srcSel,
    input  sysclkSel,
    input  prescaleTick,
    input  pin,
    output tickInt,
    output tick,
    output countEn
  );

  modport user (
    output runEn,
    output gateSel,
    output gateIn,
    output gatePol,
    output srcSel,
    output sysclkSel,
    output prescaleTick,
    output pin,
    input  tickInt,
    input  tick,
    input  countEn
  );
endinterface

// *** tb/test_timer_split_mode_control.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_timer_split_mode_control;
  localparam logic [7:0] CTL = timer_split_pkg::ADDR_RUN_FLAGS;
  localparam logic [7:0] ALO = timer_split_pkg::ADDR_A_LOW;
  localparam logic [7:0] AHI = timer_split_pkg::ADDR_A_HIGH;
  localparam logic [7:0] BLO = timer_split_pkg::ADDR_B_LOW;
  localparam logic [7:0] BHI = timer_split_pkg::ADDR_B_HIGH;
  logic       clk_sys, srst, wrEn, bitEn, bitVal, presc, aPin, gateIn, aSrc, aGate, aSys;
  logic       isrA, isrB, irqA, irqB, bTick, rdReq, rdPend;
  logic [7:0] addr, wrData, rdData, lfsr, expV;
  logic [2:0] bitIdx;
  logic [1:0] aMode, bMode, gatePol;
  logic [7:0] expQ[$];
  int         cmp_count, n_mismatch, cycles, tickCnt, falls;
  timer_split_mode_control dut_u (.clk_sys(clk_sys), .srst(srst), .sfrAddr(addr),
    .sfrWrEn(wrEn), .sfrWrData(wrData), .sfrBitWrEn(bitEn), .sfrBitIdx(bitIdx),
    .sfrBitVal(bitVal), .sfrRdData(rdData), .timerAModeSel(aMode), .timerBModeSel(bMode),
    .timer_a_count_source_sel(aSrc), .timerBCountSourceSel(aSrc), .timer_a_gate_sel(aGate),
    .timerBGateSel(1'b0), .timer_a_sysclk_sel(aSys), .timerBSysclkSel(1'b1),
    .prescaleTick(presc), .timerAPin(aPin), .timerBPin(1'b0), .timer_a_gate_input(gateIn),
    .timerBGateInput(1'b0), .gate_input_polarity(gatePol), .isrEnterA(isrA),
    .isrEnterB(isrB), .timerAIrq(irqA), .timerBIrq(irqB), .timerBOverflowTick(bTick));
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bus tasks: start after a falling edge, strobe for one cycle, one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge clk_sys);
    wrEn = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic bitwr(input logic [2:0] i, input logic v);
    addr = CTL;
    bitIdx = i;
    bitVal = v;
    bitEn = 1'b1;
    @(negedge clk_sys);
    bitEn = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    expQ.push_back(e);
    rdReq = 1'b1;
    @(negedge clk_sys);
    rdReq = 1'b0;
    @(negedge clk_sys);
  endtask
  // Loads timer A, then lets the run bit stand for four counting edges
  task automatic run_a(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
    aMode = m;
    wr(ALO, lo);
    wr(AHI, hi);
    bitwr(3'h4, 1'b1);
    repeat (2) @(negedge clk_sys);
    bitwr(3'h4, 1'b0);
  endtask
  ////////////////////////////////////////
  // Clock, timeout, tick counter and read monitor
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    rdPend <= rdReq;
    cycles++;
    if (bTick === 1'b1)
      tickCnt++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(negedge clk_sys)
    if (rdPend)
    begin
      expV = expQ.pop_front();
      `CHK(rdData, expV)
    end
  // Main sequence
  initial
  begin
    {wrEn, bitEn, bitVal, presc, aPin, gateIn, aSrc, aGate, aSys, isrA, isrB, rdReq} = '0;
    {addr, wrData, bitIdx} = '0;
    {aMode, bMode, gatePol} = 6'h3D;
    lfsr = 8'h41;
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    rd(CTL, 8'h00);
    wr(8'hF0, 8'hFF);
    rd(8'hF0, 8'h00);
    aSys = 1'b1;
    wr(ALO, 8'hFE);
    wr(AHI, 8'h7F);
    bitwr(3'h4, 1'b1);
    repeat (2) @(negedge clk_sys);
    bitwr(3'h4, 1'b0);
    `CHK(irqA, 1'b1)
    rd(ALO, 8'h02);
    rd(AHI, 8'h7F);
    rd(CTL, 8'h20);
    isrA = 1'b1;
    @(negedge clk_sys);
    isrA = 1'b0;
    rd(CTL, 8'h00);
    aSrc = 1'b1;
    wr(AHI, 8'hFD);
    bitwr(3'h6, 1'b1);
    repeat (2) @(negedge clk_sys);
    bitwr(3'h6, 1'b0);
    rd(AHI, 8'h01);
    rd(ALO, 8'h02);
    rd(BLO, 8'h00);
    rd(CTL, 8'h80);
    isrB = 1'b1;
    @(negedge clk_sys);
    isrB = 1'b0;
    rd(CTL, 8'h00);
    bitwr(3'h7, 1'b1);
    rd(CTL, 8'h80);
    bitwr(3'h7, 1'b0);
    rd(CTL, 8'h00);
    // Timer B source select is high here, yet split mode must count the clock
    wr(BLO, 8'hFE);
    wr(BHI, 8'hFF);
    tickCnt = 0;
    bMode = 2'h1;
    repeat (2) @(negedge clk_sys);
    bMode = 2'h3;
    rd(BLO, 8'h00);
    rd(BHI, 8'h00);
    rd(CTL, 8'h00);
    `CHK(tickCnt, 1)
    // Pin counting, first with the gate closed, then open
    aMode = 2'h1;
    aGate = 1'b1;
    wr(ALO, 8'h00);
    bitwr(3'h4, 1'b1);
    falls = 0;
    repeat (2)
    begin
      repeat (16)
      begin
        lfsr = lfsr_step(lfsr);
        falls += int'(gateIn && aPin && !lfsr[0]);
        aPin = lfsr[0];
        @(negedge clk_sys);
      end
      falls += int'(gateIn && aPin);
      aPin = 1'b0;
      repeat (3) @(negedge clk_sys);
      gateIn = !gateIn;
    end
    // Prescaled clock ticks
    {aSrc, aSys, aGate} = 3'h0;
    repeat (5)
    begin
      presc = 1'b1;
      @(negedge clk_sys);
      presc = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    bitwr(3'h4, 1'b0);
    rd(ALO, falls[7:0] + 8'h05);
    rd(AHI, 8'h01);
    // Reload and 13-bit modes, four clock ticks each
    aSys = 1'b1;
    run_a(2'h2, 8'hFE, 8'hC0);
    rd(ALO, 8'hC2);
    rd(AHI, 8'hC0);
    rd(CTL, 8'h20);
    bitwr(3'h5, 1'b0);
    run_a(2'h0, 8'hFE, 8'hFF);
    rd(ALO, 8'hE2);
    rd(AHI, 8'h00);
    rd(CTL, 8'h20);
    repeat (4) @(negedge clk_sys);
    tally_and_finish();
  end
endmodule

// *** tb/timer_split_mode_control_checker.sv ***
`timescale 1ns/100ps
module timer_split_mode_control_checker (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrBitWrEn,
  input wire logic [2:0] sfrBitIdx,
  input wire logic       sfrBitVal,
  input wire logic [7:0] sfrRdData,
  input wire logic [1:0] timerBModeSel,
  input wire logic       isrEnterA,
  input wire logic       timerAIrq,
  input wire logic       timerBIrq,
  input wire logic       timerBOverflowTick
);
  localparam logic [7:0] CTL = timer_split_pkg::ADDR_RUN_FLAGS;
  logic [7:0] shadow_r;
  logic       ctlWr;
  logic       ctlBit;
  logic       setA;
  logic       setB;
  // Decode software writes to the control register
  assign ctlWr  = sfrWrEn && sfrAddr == CTL;
  assign ctlBit = sfrBitWrEn && !sfrWrEn && sfrAddr == CTL;
  assign setA   = (ctlWr && sfrWrData[5]) || (ctlBit && sfrBitIdx == 3'h5 && sfrBitVal);
  assign setB   = (ctlWr && sfrWrData[7]) || (ctlBit && sfrBitIdx == 3'h7 && sfrBitVal);
  // Shadow of what software wrote
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      shadow_r <= 8'h00;
    else if (ctlWr)
      shadow_r <= sfrWrData;
    else if (ctlBit)
      shadow_r[sfrBitIdx] <= sfrBitVal;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_ctl_read; $past(sfrAddr) == CTL; endsequence
  sequence s_a_idle; !shadow_r[4] [*3]; endsequence
  sequence s_b_idle; !shadow_r[6] [*3]; endsequence
  property p_reset;
    disable iff (1'b0) srst |=> sfrRdData == 8'h00 && !timerAIrq && !timerBIrq && !timerBOverflowTick;
  endproperty
  property p_ctl_read; s_ctl_read |-> (sfrRdData & 8'h5F) == ($past(shadow_r) & 8'h5F); endproperty
  property p_flag_read;
    s_ctl_read |-> sfrRdData[7] == $past(timerBIrq) && sfrRdData[5] == $past(timerAIrq);
  endproperty
  property p_a_flag_hold; s_a_idle ##0 (!timerAIrq && !setA) |=> !timerAIrq; endproperty
  property p_isr_clear_a; s_a_idle ##0 (isrEnterA && !setA) |=> !timerAIrq; endproperty
  property p_b_flag_hold; s_b_idle ##0 (!timerBIrq && !setB) |=> !timerBIrq; endproperty
  property p_sw_clear_b;
    s_b_idle ##0 (ctlBit && sfrBitIdx == 3'h7 && !sfrBitVal) |=> !timerBIrq;
  endproperty
  property p_b_mode3_idle;
    timerBModeSel == 2'h3 && $past(timerBModeSel) == 2'h3 && $past(timerBModeSel, 2) == 2'h3
      |-> !timerBOverflowTick;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  a_ctl_read: assert property (p_ctl_read)
    else $error("run bit readback wrong");
  a_flag_read: assert property (p_flag_read)
    else $error("flag readback wrong");
  a_a_flag_hold: assert property (p_a_flag_hold)
    else $error("flag A set while stopped");
  a_isr_clear_a: assert property (p_isr_clear_a)
    else $error("flag A not cleared");
  a_b_flag_hold: assert property (p_b_flag_hold)
    else $error("flag B set wrongly");
  a_sw_clear_b: assert property (p_sw_clear_b)
    else $error("flag B not cleared");
  a_b_mode3_idle: assert property (p_b_mode3_idle)
    else $error("timer B ran in mode 3");
endmodule
bind timer_split_mode_control timer_split_mode_control_checker chk_u (.clk_sys(clk_sys),
  .srst(srst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
  .sfrBitWrEn(sfrBitWrEn), .sfrBitIdx(sfrBitIdx), .sfrBitVal(sfrBitVal),
  .sfrRdData(sfrRdData), .timerBModeSel(timerBModeSel), .isrEnterA(isrEnterA),
  .timerAIrq(timerAIrq), .timerBIrq(timerBIrq), .timerBOverflowTick(timerBOverflowTick));
